/* File: ebpsc_ctrl.sv */
// Expansion bus controller: runs external bus cycles and sets each pin's drive state.
// Assumes a core that requests one access at a time and drives power-mode levels.
//
// Behaviour
// - After reset all bus pins but the clock output are undriven port inputs.
// - With expansion mode on, run mode and no external cycle, the bus cycle is inactive.
// - Held address and byte enables are zero before the first access.
// - Held outputs keep the last external access values, even across mode toggles.
// - Address/data outputs are undriven in every non-cycle state.
// - Lower address undriven in reset, held in every other listed state.
// - Upper address undriven in reset, low-power and hold; held otherwise.
// - Byte enables undriven in reset, low-power and hold; held otherwise.
// - Read/write undriven in reset, low-power and hold; low in write cycles, high otherwise.
// - Data, read and byte write strobes undriven likewise; high when idle.
// - Address strobe undriven in reset, low-power and hold; high when idle.
// - Hold request watched in halt, hold and inactive cycles; not in low-power.
// - Hold acknowledge low in hold, undriven in reset and low-power.
// - Clock output undriven in reset, low in low-power, toggling otherwise.
// - Clock output inhibit forces the clock output low.
// - Wait request stretches the current cycle while it stays asserted.
// - Separate high and low byte write strobes.
// - Address in the first state, data in second, wait and third states.
// - Hold request is granted with acknowledge and released bus pins other than the lower address and the clock output.
module ebpsc_ctrl
  import ebpsc_pkg::*;
(
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_exp_mode,
  input  wire logic                         i_halt_req,
  input  wire logic                         i_lowpwr_req,
  input  wire logic                         i_sys_clock_out_inhibit,
  input  wire logic                         i_acc_req,
  input  wire logic                         i_acc_we,
  input  wire logic [ebpsc_pkg::ADDR_W-1:0] i_acc_addr,
  input  wire logic [1:0]                   i_acc_be,
  input  wire logic [ebpsc_pkg::DATA_W-1:0] i_acc_wdata,
  output logic                              o_acc_ack,
  output logic [ebpsc_pkg::DATA_W-1:0]      o_acc_rdata,
  output logic                              o_bus_inactive,
  input  wire logic                         i_hold_request_in_n,
  input  wire logic                         i_wait_n,
  input  wire logic [ebpsc_pkg::DATA_W-1:0] i_muxed_addr_data_in,
  output logic [ebpsc_pkg::DATA_W-1:0]      o_muxed_addr_data_out,
  output logic                              o_muxed_addr_data_oe,
  output logic [14:0]                       o_lower_addr_out,
  output logic                              o_lower_addr_oe,
  output logic [5:0]                        o_upper_addr_out,
  output logic                              o_upper_addr_oe,
  output logic                              o_low_byte_enable_n,
  output logic                              o_high_byte_enable_n,
  output logic                              o_byte_enable_oe,
  output logic                              o_rw_dir,
  output logic                              o_rw_dir_oe,
  output logic                              o_data_strobe_n,
  output logic                              o_read_strobe_n,
  output logic                              o_low_byte_write_strobe_n,
  output logic                              o_high_byte_write_strobe_n,
  output logic                              o_strobe_oe,
  output logic                              o_addr_strobe_n,
  output logic                              o_addr_strobe_oe,
  output logic                              o_hold_ack_out_n,
  output logic                              o_hold_ack_oe,
  output logic                              o_sys_clock_out,
  output logic                              o_sys_clock_oe
);
  import ebpsc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic data_phase(input ebpsc_bus_t b);
    data_phase = (b == BUS_T2) || (b == BUS_TW) || (b == BUS_T3);
  endfunction

  // Low-power and hold release the control pins; halt and idle keep them.
  function automatic logic ctl_driven(input ebpsc_pwr_t p);
    ctl_driven = (p != PWR_LOW) && (p != PWR_HOLD);
  endfunction

  ebpsc_link_if lnk ();

  ebpsc_sync u_sync (
    .i_sys_clk           (i_sys_clk),
    .i_rst               (i_rst),
    .i_hold_request_in_n (i_hold_request_in_n),
    .i_wait_n            (i_wait_n),
    .i_ad_in             (i_muxed_addr_data_in),
    .lnk                 (lnk.sync_mp)
  );

  ebpsc_clkdiv #(
    .HALF_CYC (CLK_HALF_CYC)
  ) u_div (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .lnk       (lnk.div_mp)
  );

  ebpsc_state_t s_q;
  ebpsc_state_t s_d;
  logic         busy;
  logic         hold_ok;
  logic         full;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d     = s_q;
    s_d.ack = 1'b0;
    busy    = (s_q.bus != BUS_IDLE) || (s_q.rd_cnt != 2'h0);
    hold_ok = lnk.hold_req && s_q.exp;
    s_d.clk_oe = 1'b1;
    if (lnk.tick) begin
      s_d.clk = ~s_q.clk;
    end
    if ((s_q.pwr == PWR_LOW) || i_sys_clock_out_inhibit) begin
      s_d.clk = 1'b0;
    end
    if (!busy && (s_q.pwr != PWR_HOLD)) begin
      s_d.exp = i_exp_mode;
    end
    // Read data arrives two edges late through the synchroniser.
    if (s_q.rd_cnt != 2'h0) begin
      s_d.rd_cnt = s_q.rd_cnt - 2'h1;
    end
    if (s_q.rd_cnt == 2'h1) begin
      s_d.rdata = lnk.ad_in;
      s_d.ack   = 1'b1;
    end
    case (s_q.bus)
      BUS_IDLE: begin
        if (!busy) begin
          case (s_q.pwr)
            PWR_RUN: begin
              if (hold_ok) begin
                s_d.pwr = PWR_HOLD;
              end else if (i_lowpwr_req) begin
                s_d.pwr = PWR_LOW;
              end else if (i_halt_req) begin
                s_d.pwr = PWR_HALT;
              end else if (i_acc_req && !s_q.ack && s_q.exp) begin
                s_d.bus   = BUS_T1;
                s_d.addr  = i_acc_addr;
                s_d.be    = i_acc_be;
                s_d.wr    = i_acc_we;
                s_d.wdata = i_acc_wdata;
                s_d.ad    = i_acc_addr[DATA_W-1:0];
              end
            end
            PWR_HALT: begin
              if (hold_ok) begin
                s_d.pwr = PWR_HOLD;
              end else if (i_lowpwr_req) begin
                s_d.pwr = PWR_LOW;
              end else if (!i_halt_req) begin
                s_d.pwr = PWR_RUN;
              end
            end
            PWR_LOW: begin
              if (!i_lowpwr_req) begin
                s_d.pwr = PWR_RUN;
              end
            end
            PWR_HOLD: begin
              if (!lnk.hold_req) begin
                s_d.pwr = PWR_RUN;
              end
            end
            default: begin
              s_d.pwr = PWR_RUN;
            end
          endcase
        end
      end
      BUS_T1: begin
        s_d.bus = BUS_T2;
        s_d.ad  = s_q.wdata;
      end
      BUS_T2: begin
        s_d.bus = lnk.wait_req ? BUS_TW : BUS_T3;
      end
      BUS_TW: begin
        if (!lnk.wait_req) begin
          s_d.bus = BUS_T3;
        end
      end
      BUS_T3: begin
        s_d.bus = BUS_IDLE;
        if (s_q.wr) begin
          s_d.ack = 1'b1;
        end else begin
          s_d.rd_cnt = RD_SYNC_LAT;
        end
      end
      default: begin
        s_d.bus = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // bus pins other than the clock output follow expansion mode
  assign full = s_q.exp && ctl_driven(s_q.pwr);

  assign o_bus_inactive = s_q.exp && (s_q.pwr == PWR_RUN) && (s_q.bus == BUS_IDLE);
  assign o_acc_ack      = s_q.ack;
  assign o_acc_rdata    = s_q.rdata;

  assign o_muxed_addr_data_out = s_q.ad;
  assign o_muxed_addr_data_oe  = s_q.exp &&
                                 ((s_q.bus == BUS_T1) || (s_q.wr && data_phase(s_q.bus)));

  assign o_lower_addr_out = s_q.addr[LO_ADDR_MSB:LO_ADDR_LSB];
  assign o_lower_addr_oe  = s_q.exp;

  assign o_upper_addr_out = s_q.addr[UP_ADDR_MSB:UP_ADDR_LSB];
  assign o_upper_addr_oe  = full;

  assign o_low_byte_enable_n  = ~s_q.be[0];
  assign o_high_byte_enable_n = ~s_q.be[1];
  assign o_byte_enable_oe     = full;

  assign o_rw_dir    = (s_q.bus == BUS_IDLE) ? 1'b1 : ~s_q.wr;
  assign o_rw_dir_oe = full;

  assign o_data_strobe_n = ~data_phase(s_q.bus);
  assign o_read_strobe_n = ~(data_phase(s_q.bus) && !s_q.wr);
  assign o_low_byte_write_strobe_n  = ~(data_phase(s_q.bus) && s_q.wr && s_q.be[0]);
  assign o_high_byte_write_strobe_n = ~(data_phase(s_q.bus) && s_q.wr && s_q.be[1]);
  assign o_strobe_oe                = full;

  assign o_addr_strobe_n  = ~(s_q.bus == BUS_T1);
  assign o_addr_strobe_oe = full;

  assign o_hold_ack_out_n = ~(s_q.pwr == PWR_HOLD);
  assign o_hold_ack_oe    = s_q.exp && (s_q.pwr != PWR_LOW);

  assign o_sys_clock_out = s_q.clk;
  assign o_sys_clock_oe  = s_q.clk_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_addr_phase;
    (s_q.bus == BUS_T1) && !o_addr_strobe_n;
  endsequence

  sequence s_data_start;
    (s_q.bus == BUS_T2) && !o_data_strobe_n;
  endsequence

  sequence s_wait_seen;
    (s_q.bus == BUS_TW) && lnk.wait_req;
  endsequence

  a_reset_pins_off: assert property (
    disable iff (1'b0) i_rst |=> !o_muxed_addr_data_oe && !o_lower_addr_oe
      && !o_strobe_oe && !o_hold_ack_oe && !o_sys_clock_oe)
    else $error("bus pins driven after reset");

  a_cycle_phases: assert property (
    s_addr_phase |=> s_data_start ##1 (s_q.bus != BUS_T1)[*2])
    else $error("bus cycle phase order wrong");

  a_ad_released: assert property (
    (s_q.bus == BUS_IDLE) |-> !o_muxed_addr_data_oe)
    else $error("address/data driven outside a cycle");

  a_addr_held_idle: assert property (
    (s_q.bus == BUS_IDLE) ##1 (s_q.bus == BUS_IDLE)
      |-> $stable(o_lower_addr_out) && $stable(o_upper_addr_out))
    else $error("address changed outside a cycle");

  a_ctl_released: assert property (
    s_q.exp && ((s_q.pwr == PWR_LOW) || (s_q.pwr == PWR_HOLD))
      |-> !o_upper_addr_oe && !o_byte_enable_oe && !o_rw_dir_oe && !o_addr_strobe_oe)
    else $error("control pins driven in hold or low power");

  a_idle_levels: assert property (
    o_bus_inactive |-> o_rw_dir && o_data_strobe_n && o_read_strobe_n
      && o_addr_strobe_n && o_strobe_oe)
    else $error("idle strobe levels wrong");

  a_byte_strobes: assert property (
    !o_high_byte_write_strobe_n |-> s_q.wr && s_q.be[1] && !o_rw_dir)
    else $error("high byte write strobe without its byte");

  a_wait_stretch: assert property (
    s_wait_seen |=> (s_q.bus == BUS_TW))
    else $error("wait state left early");

  a_hold_after_cycle: assert property (
    $rose(s_q.pwr == PWR_HOLD) |-> $past(s_q.bus) == BUS_IDLE && !o_hold_ack_out_n)
    else $error("hold granted during a cycle");

  a_no_hold_low: assert property (
    (s_q.pwr == PWR_LOW) |=> (s_q.pwr != PWR_HOLD))
    else $error("hold taken in low power");

  a_clk_inhibit: assert property (
    i_sys_clock_out_inhibit |=> !o_sys_clock_out && o_sys_clock_oe)
    else $error("clock output not low under inhibit");

  a_read_ack: assert property (
    (s_q.bus == BUS_T3) && !s_q.wr |=> !o_acc_ack ##1 !o_acc_ack ##1 o_acc_ack)
    else $error("read acknowledge timing wrong");

endmodule

/* File: ebpsc_pkg.sv */
// Shared types and constants of the expansion bus pin-state controller.
// Assumes a single 250 MHz system clock and a synchronous active-high reset.
package ebpsc_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W       = 22;
  localparam int DATA_W       = 16;
  localparam int LO_ADDR_LSB  = 1;
  localparam int LO_ADDR_MSB  = 15;
  localparam int UP_ADDR_LSB  = 16;
  localparam int UP_ADDR_MSB  = 21;
  localparam int SYNC_W       = DATA_W + 2;
  localparam int CLK_HALF_CYC = 1;
  localparam logic [1:0] RD_SYNC_LAT = 2'h2;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE = 3'h0,
    BUS_T1   = 3'h1,
    BUS_T2   = 3'h2,
    BUS_TW   = 3'h3,
    BUS_T3   = 3'h4
  } ebpsc_bus_t;

  typedef enum logic [1:0] {
    PWR_RUN  = 2'h0,
    PWR_HALT = 2'h1,
    PWR_LOW  = 2'h2,
    PWR_HOLD = 2'h3
  } ebpsc_pwr_t;

  typedef struct packed {
    ebpsc_bus_t          bus;
    ebpsc_pwr_t          pwr;
    logic                exp;
    logic                clk_oe;
    logic                clk;
    logic [ADDR_W-1:0]   addr;
    logic [1:0]          be;
    logic                wr;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   ad;
    logic [DATA_W-1:0]   rdata;
    logic                ack;
    logic [1:0]          rd_cnt;
  } ebpsc_state_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 22'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam ebpsc_state_t ST_RST = '{
    bus: BUS_IDLE, pwr: PWR_RUN, exp: 1'b0, clk_oe: 1'b0, clk: 1'b0,
    addr: ADDR_RST, be: 2'h0, wr: 1'b0, wdata: DATA_RST, ad: DATA_RST,
    rdata: DATA_RST, ack: 1'b0, rd_cnt: 2'h0};

endpackage

/* File: ebpsc_link_if.sv */
// Internal carrier between the pin synchroniser, the clock divider and the core.
// Assumes all three sit on the same system clock.
interface ebpsc_link_if;
  logic                           hold_req;
  logic                           wait_req;
  logic [ebpsc_pkg::DATA_W-1:0]   ad_in;
  logic                           tick;

  modport sync_mp (output hold_req, output wait_req, output ad_in);
  modport div_mp  (output tick);
  modport core_mp (input hold_req, input wait_req, input ad_in, input tick);
endinterface

/* File: ebpsc_sync.sv */
// Two-stage synchroniser for the hold request, wait and address/data pins.
// Assumes the pins are asynchronous to the system clock; pin requests are active low.
module ebpsc_sync
  import ebpsc_pkg::*;
(
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_hold_request_in_n,
  input  wire logic                         i_wait_n,
  input  wire logic [ebpsc_pkg::DATA_W-1:0] i_ad_in,
  ebpsc_link_if.sync_mp                     lnk
);

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
  } ebpsc_sync_t;

  ebpsc_sync_t s_q;
  ebpsc_sync_t s_d;

  // Idle pins read high, so the requests come out of reset inactive.
  localparam logic [SYNC_W-1:0] SYNC_RST = {2'h3, DATA_RST};

  always_comb begin
    s_d    = s_q;
    s_d.s1 = {i_hold_request_in_n, i_wait_n, i_ad_in};
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q <= '{s1: SYNC_RST, s2: SYNC_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.hold_req = ~s_q.s2[SYNC_W-1];
  assign lnk.wait_req = ~s_q.s2[SYNC_W-2];
  assign lnk.ad_in    = s_q.s2[DATA_W-1:0];

endmodule

/* File: ebpsc_clkdiv.sv */
// Divider that issues a one-cycle tick for each half period of the clock output.
// Assumes the system clock; HALF_CYC is the half period in system cycles.
module ebpsc_clkdiv
  import ebpsc_pkg::*;
#(
  parameter int HALF_CYC = CLK_HALF_CYC
)
(
  input  wire logic     i_sys_clk,
  input  wire logic     i_rst,
  ebpsc_link_if.div_mp  lnk
);

  localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
  } ebpsc_div_t;

  ebpsc_div_t s_q;
  ebpsc_div_t s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.cnt == LAST) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q <= '{cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.tick = (s_q.cnt == LAST);

endmodule

/* File: ebpsc_ext_mem.sv */
// External memory and bus-hold requester as seen from the expansion bus pins.
// Assumes the controller's pin outputs and the same system clock.
module ebpsc_ext_mem (
  input  wire logic        i_sys_clk,
  input  wire logic        i_hold_want,
  input  wire logic [3:0]  i_wait_len,
  input  wire logic [15:0] i_ad_out,
  input  wire logic        i_ad_oe,
  input  wire logic        i_addr_strobe_n,
  input  wire logic        i_addr_strobe_oe,
  input  wire logic        i_read_strobe_n,
  input  wire logic        i_lo_wr_n,
  input  wire logic        i_hi_wr_n,
  input  wire logic        i_strobe_oe,
  output logic [15:0]      o_ad_in,
  output logic             o_wait_n,
  output logic             o_hold_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_q [16];
  logic [3:0]  idx_q;
  logic [3:0]  wcnt_q;
  logic [15:0] last_q;
  logic        done_q;
  logic        rd_drv;
  logic        t1_now;

  initial begin
    foreach (mem_q[i]) mem_q[i] = 16'h0000;
    idx_q = 4'h0;
    wcnt_q = 4'h0;
    done_q = 1'b0;
    last_q = 16'h0000;
    o_hold_n = 1'b1;
  end

  assign t1_now = i_addr_strobe_oe && !i_addr_strobe_n;
  assign rd_drv = i_strobe_oe && !i_read_strobe_n && !i_ad_oe;
  // A released bus shows the inverse of its last level, so stale data never matches.
  assign o_ad_in = i_ad_oe ? i_ad_out : (rd_drv ? mem_q[idx_q] : ~last_q);
  // A slow device holds wait low until its delay after the address strobe runs out.
  // The controller sees the pin two cycles late, so a wait raised only in T1 would be missed.
  assign o_wait_n = !(i_wait_len != 4'h0 && !done_q);

  always @(posedge i_sys_clk) begin
    // Hold request follows the bench's wish.
    o_hold_n <= ~i_hold_want;
    last_q <= o_ad_in;
    if (t1_now) begin
      idx_q <= i_ad_out[4:1];
      wcnt_q <= i_wait_len;
    end else if (wcnt_q != 4'h0) begin
      wcnt_q <= wcnt_q - 4'h1;
    end
    done_q <= (i_wait_len != 4'h0) && (done_q || wcnt_q == 4'h1);
    if (i_strobe_oe && !i_lo_wr_n) mem_q[idx_q][7:0] <= i_ad_out[7:0];
    if (i_strobe_oe && !i_hi_wr_n) mem_q[idx_q][15:8] <= i_ad_out[15:8];
  end
endmodule

/* File: tb_ebpsc_ctrl.sv */
// Self-checking bench for the expansion bus pin-state controller.
// Assumes the external memory model and a 250 MHz clock.
module tb_ebpsc_ctrl
  import ebpsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_sys_clk, i_rst, i_exp_mode, i_halt_req, i_lowpwr_req, i_sys_clock_out_inhibit;
  logic i_acc_req, i_acc_we, o_acc_ack, o_bus_inactive, o_muxed_addr_data_oe;
  logic o_lower_addr_oe, o_upper_addr_oe, o_low_byte_enable_n, o_high_byte_enable_n;
  logic o_byte_enable_oe, o_rw_dir, o_rw_dir_oe, o_data_strobe_n, o_read_strobe_n;
  logic o_low_byte_write_strobe_n, o_high_byte_write_strobe_n, o_strobe_oe;
  logic o_addr_strobe_n, o_addr_strobe_oe, o_hold_ack_out_n, o_hold_ack_oe;
  logic o_sys_clock_out, o_sys_clock_oe, hold_n, wait_n, hold_want;
  logic [14:0]       o_lower_addr_out;
  logic [5:0]        o_upper_addr_out;
  logic [1:0]        i_acc_be;
  logic [3:0]        wait_len;
  logic [ADDR_W-1:0] i_acc_addr;
  logic [DATA_W-1:0] i_acc_wdata, o_acc_rdata, ad_in, o_muxed_addr_data_out, rd;
  int                err_count, n_checks, cyc, lat, plain_lat;
  localparam logic [21:0] A = 22'h2A1234;

  ebpsc_ctrl u_ebpsc_ctrl (
    .i_sys_clk, .i_rst, .i_exp_mode, .i_halt_req, .i_lowpwr_req, .i_sys_clock_out_inhibit,
    .i_acc_req, .i_acc_we, .i_acc_addr, .i_acc_be, .i_acc_wdata, .o_acc_ack, .o_acc_rdata,
    .o_bus_inactive, .i_hold_request_in_n(hold_n), .i_wait_n(wait_n),
    .i_muxed_addr_data_in(ad_in), .o_muxed_addr_data_out, .o_muxed_addr_data_oe,
    .o_lower_addr_out, .o_lower_addr_oe, .o_upper_addr_out, .o_upper_addr_oe,
    .o_low_byte_enable_n, .o_high_byte_enable_n, .o_byte_enable_oe, .o_rw_dir, .o_rw_dir_oe,
    .o_data_strobe_n, .o_read_strobe_n, .o_low_byte_write_strobe_n,
    .o_high_byte_write_strobe_n, .o_strobe_oe, .o_addr_strobe_n, .o_addr_strobe_oe,
    .o_hold_ack_out_n, .o_hold_ack_oe, .o_sys_clock_out, .o_sys_clock_oe);

  ebpsc_ext_mem u_ebpsc_ext_mem (
    .i_sys_clk, .i_hold_want(hold_want), .i_wait_len(wait_len),
    .i_ad_out(o_muxed_addr_data_out), .i_ad_oe(o_muxed_addr_data_oe),
    .i_addr_strobe_n(o_addr_strobe_n), .i_addr_strobe_oe(o_addr_strobe_oe),
    .i_read_strobe_n(o_read_strobe_n), .i_lo_wr_n(o_low_byte_write_strobe_n),
    .i_hi_wr_n(o_high_byte_write_strobe_n), .i_strobe_oe(o_strobe_oe),
    .o_ad_in(ad_in), .o_wait_n(wait_n), .o_hold_n(hold_n));

  always #2 i_sys_clk = ~i_sys_clk;

  // The whole run needs well under a thousand cycles.
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic off_chk(input logic lo_oe);
    chk({o_muxed_addr_data_oe, o_upper_addr_oe, o_byte_enable_oe, o_rw_dir_oe, o_strobe_oe,
         o_addr_strobe_oe, o_lower_addr_oe}, {6'h00, lo_oe});
  endtask

  task automatic idle_chk(input logic [21:0] a, input logic [1:0] be, input logic inact);
    chk({o_bus_inactive, o_muxed_addr_data_oe, o_lower_addr_oe, o_upper_addr_oe,
         o_byte_enable_oe, o_rw_dir_oe, o_strobe_oe, o_addr_strobe_oe}, {inact, 7'h3F});
    chk({o_lower_addr_out, o_upper_addr_out}, {a[15:1], a[21:16]});
    chk({o_low_byte_enable_n, o_high_byte_enable_n}, {~be[0], ~be[1]});
    chk({o_rw_dir, o_data_strobe_n, o_read_strobe_n, o_low_byte_write_strobe_n,
         o_high_byte_write_strobe_n, o_addr_strobe_n}, 6'h3F);
  endtask

  task automatic clk_chk(input int n_exp, input logic lvl);
    int   n;
    logic p;
    settle(1);
    p = o_sys_clock_out;
    n = 0;
    repeat (8) begin
      settle(1);
      if (o_sys_clock_out !== p) n++;
      p = o_sys_clock_out;
    end
    chk(n, n_exp);
    if (n_exp == 0) chk({o_sys_clock_oe, o_sys_clock_out}, {1'b1, lvl});
  endtask

  task automatic wait_hold(input logic lvl);
    int n;
    for (n = 0; n < 12 && o_hold_ack_out_n !== lvl; n++) settle(1);
    chk({o_hold_ack_oe, o_hold_ack_out_n}, {1'b1, lvl});
  endtask

  task automatic acc(input logic we, input logic [21:0] a, input logic [1:0] be,
                     input logic [15:0] wd, output logic [15:0] r, output int n);
    @(posedge i_sys_clk);
    i_acc_we <= we;
    i_acc_addr <= a;
    i_acc_be <= be;
    i_acc_wdata <= wd;
    i_acc_req <= 1'b1;
    for (n = 1; n < 60; n++) begin
      settle(1);
      if (o_addr_strobe_oe && !o_addr_strobe_n) begin
        chk({o_muxed_addr_data_oe, o_muxed_addr_data_out, o_rw_dir}, {1'b1, a[15:0], !we});
      end
      if (we && !o_data_strobe_n) begin
        chk({o_muxed_addr_data_out, o_low_byte_write_strobe_n, o_high_byte_write_strobe_n},
            {wd, !be[0], !be[1]});
      end
      if (!we && !o_data_strobe_n) begin
        chk({o_read_strobe_n, o_muxed_addr_data_oe, o_rw_dir}, 3'h1);
      end
      if (o_acc_ack === 1'b1) break;
    end
    chk(o_acc_ack, 1);
    r = o_acc_rdata;
    @(posedge i_sys_clk);
    i_acc_req <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    settle(7);
    chk({o_sys_clock_oe, o_hold_ack_oe}, 0);
    off_chk(0);
    @(posedge i_sys_clk);
    i_rst <= 1'b0;
    settle(3);
    off_chk(0);
    clk_chk(8, 1'b0);
    $display("test reset finished");
  endtask

  task automatic t_access();
    @(posedge i_sys_clk);
    i_exp_mode <= 1'b1;
    settle(3);
    acc(1'b1, A, 2'h3, 16'hA5C3, rd, lat);
    acc(1'b1, A, 2'h1, 16'h1111, rd, lat);
    acc(1'b1, A, 2'h2, 16'h2200, rd, lat);
    acc(1'b1, A, 2'h0, 16'hFFFF, rd, lat);
    chk(lat, 4);
    acc(1'b0, A, 2'h3, 16'h0000, rd, plain_lat);
    chk(plain_lat, 6);
    chk(rd, 16'h2211);
    settle(2);
    idle_chk(A, 2'h3, 1'b1);
    $display("test access finished");
  endtask

  task automatic t_wait();
    @(posedge i_sys_clk);
    wait_len <= 4'h4;
    acc(1'b0, A, 2'h3, 16'h0000, rd, lat);
    chk({rd, 15'h0000, lat > plain_lat}, {16'h2211, 16'h0001});
    wait_len <= 4'h0;
    $display("test wait finished");
  endtask

  task automatic t_hold();
    fork
      acc(1'b1, A, 2'h3, 16'h3344, rd, lat);
      begin
        repeat (2) @(posedge i_sys_clk);
        hold_want <= 1'b1;
      end
    join
    wait_hold(1'b0);
    off_chk(1);
    chk(o_lower_addr_out, A[15:1]);
    clk_chk(8, 1'b0);
    @(posedge i_sys_clk);
    hold_want <= 1'b0;
    wait_hold(1'b1);
    settle(2);
    idle_chk(A, 2'h3, 1'b1);
    $display("test hold finished");
  endtask

  task automatic t_halt();
    @(posedge i_sys_clk);
    i_halt_req <= 1'b1;
    settle(3);
    idle_chk(A, 2'h3, 1'b0);
    chk({o_hold_ack_oe, o_hold_ack_out_n}, 2'h3);
    clk_chk(8, 1'b0);
    @(posedge i_sys_clk);
    hold_want <= 1'b1;
    wait_hold(1'b0);
    @(posedge i_sys_clk);
    hold_want <= 1'b0;
    wait_hold(1'b1);
    @(posedge i_sys_clk);
    i_sys_clock_out_inhibit <= 1'b1;
    settle(2);
    clk_chk(0, 1'b0);
    @(posedge i_sys_clk);
    i_sys_clock_out_inhibit <= 1'b0;
    i_halt_req <= 1'b0;
    $display("test halt finished");
  endtask

  task automatic t_lowpwr();
    @(posedge i_sys_clk);
    i_lowpwr_req <= 1'b1;
    settle(3);
    off_chk(1);
    chk({o_hold_ack_oe, o_lower_addr_out}, {1'b0, A[15:1]});
    clk_chk(0, 1'b0);
    @(posedge i_sys_clk);
    hold_want <= 1'b1;
    settle(6);
    chk(o_hold_ack_oe, 0);
    @(posedge i_sys_clk);
    hold_want <= 1'b0;
    settle(4);
    @(posedge i_sys_clk);
    i_lowpwr_req <= 1'b0;
    settle(4);
    idle_chk(A, 2'h3, 1'b1);
    $display("test low power finished");
  endtask

  task automatic t_exp();
    @(posedge i_sys_clk);
    i_exp_mode <= 1'b0;
    settle(3);
    off_chk(0);
    @(posedge i_sys_clk);
    i_exp_mode <= 1'b1;
    settle(3);
    idle_chk(A, 2'h3, 1'b1);
    $display("test expansion toggle finished");
  endtask

  initial begin
    {i_sys_clk, i_exp_mode, i_halt_req, i_lowpwr_req, i_sys_clock_out_inhibit} = 5'h00;
    {i_acc_req, i_acc_we, i_acc_be, hold_want, wait_len} = 9'h000;
    i_rst = 1'b1;
    i_acc_addr = 22'h000000;
    i_acc_wdata = 16'h0000;
    {err_count, n_checks, cyc} = 96'h0;
    t_reset();
    t_access();
    t_wait();
    t_hold();
    t_halt();
    t_lowpwr();
    t_exp();
    tally_and_finish();
  end
endmodule
